// file: logic/cmp_edge_pkg.sv
// Constants shared by the comparator edge control block.
package cmp_edge_pkg;
	// Control register field positions and reset value.
	localparam int unsigned       CTRL_ENABLE_BIT = 7;
	localparam int unsigned       CTRL_OUT_BIT    = 6;
	localparam int unsigned       CTRL_RISE_BIT   = 5;
	localparam int unsigned       CTRL_FALL_BIT   = 4;
	localparam logic [7:0]        CTRL_RESET      = 8'h00;
	// Input select register reset value: negative field high nibble, positive low.
	localparam logic [7:0]        MUX_RESET       = 8'h77;
	// Mode register field positions and reset value.
	localparam int unsigned       MODE_RISE_IE_BIT = 5;
	localparam int unsigned       MODE_FALL_IE_BIT = 4;
	localparam logic [7:0]        MODE_RESET      = 8'h02;
	// Hysteresis codes.
	localparam logic [1:0]        HYST_OFF        = 2'h0;
	localparam logic [1:0]        HYST_5MV        = 2'h1;
	localparam logic [1:0]        HYST_10MV       = 2'h2;
	localparam logic [1:0]        HYST_20MV       = 2'h3;
	// Response time codes.
	localparam logic [1:0]        RESP_FASTEST    = 2'h0;
	localparam logic [1:0]        RESP_LOW_POWER  = 2'h3;
endpackage : cmp_edge_pkg

// file: logic/comparator_edge_control.sv
// Digital control around the analog comparator: settings, edge flags, outputs.
//
// Notes on behaviour
// RL1: Latched and raw outputs for pin routing.
// RL2: Raw output follows comparator without clock.
// RL3: Comparator output offered as reset source.
// RL4: Separate positive and negative input selects.
// RL5: Disabled comparator drives pin outputs low.
// RL6: Response time setting passed to core.
// RL7: Low four control bits hold hysteresis.
// RL8: Interrupt on rising, falling or both.
// RL9: Falling edge sets fall flag; rising sets rise.
// RL10: Edge flags stay set until cleared.
// RL11: Output state readable at any time.
// RL12: Enable bit one on, zero off.
// RL13: Enabled and output low requests wake.
// RL14: Spurious flags possible on enable or change.
// RL15: Software clears flags after settling.
// RL16: Control register layout, resets to zero.
// RL17: Edge irq needs own and system enable.
// RL18: Hysteresis codes off, 5, 10, 20 mV.
// RL19: Two-bit response mode, resets to two.
// RL20: Two-stage synchroniser feeds edges and latch.
// RL21: Write zero clears flag; set wins.
`timescale 1ns/1ns
`default_nettype none
module comparator_edge_control (
	// Clock and reset.
	input  wire logic       clock,
	input  wire logic       arst_n,
	// Analog core.
	input  wire logic       cmp_decision,
	output logic            cmp_power_on,
	output logic [3:0]      pos_input_sel,
	output logic [3:0]      neg_input_sel,
	output logic [1:0]      pos_hyst_sel,
	output logic [1:0]      neg_hyst_sel,
	output logic [1:0]      response_time_sel,
	// Software control writes.
	input  wire logic       ctrl_wr,
	input  wire logic [7:0] ctrl_wdata,
	input  wire logic       mux_wr,
	input  wire logic [7:0] mux_wdata,
	input  wire logic       mode_wr,
	input  wire logic [7:0] mode_wdata,
	input  wire logic       system_cmp_irq_enable,
	// Software readback.
	output logic [7:0]      cmp_control_reg,
	output logic [7:0]      cmp_input_select_reg,
	output logic [7:0]      cmp_mode_reg,
	// Pin, reset, wake and interrupt outputs.
	output logic            cmp_latched_out,
	output logic            cmp_raw_out,
	output logic            cmp_reset_src,
	output logic            wake_request,
	output logic            rise_irq,
	output logic            fall_irq
);
	////////////////////////////////////////////////////////////////////////////
	logic       enable_q;
	logic       rise_flag_q;
	logic       fall_flag_q;
	logic [3:0] hyst_q;
	logic [7:0] mux_q;
	logic       rise_ie_q;
	logic       fall_ie_q;
	logic [1:0] resp_q;
	logic       sync1_q;
	logic       sync2_q;
	logic       prev_q;
	logic       latched_q;
	logic       rise_irq_q;
	logic       fall_irq_q;
	logic       wake_q;
	logic       en_dly1_q;
	logic       en_dly2_q;

	// The decision is gated after the synchroniser, by an enable delayed through the
	// same two stages, so the edge, latch and wake logic never reads the pin unsynchronised.
	wire logic  out_state = sync2_q & en_dly2_q;   // RL20
	// The latched pin output follows the enable of the same edge, so it is low
	// from the first cycle in which the comparator is off.
	wire logic  enable_d = ctrl_wr ? ctrl_wdata[cmp_edge_pkg::CTRL_ENABLE_BIT] : enable_q;
	wire logic  rise_det = out_state & ~prev_q;   // RL20
	wire logic  fall_det = ~out_state & prev_q;   // RL20
	wire logic  rise_clr = ctrl_wr & ~ctrl_wdata[cmp_edge_pkg::CTRL_RISE_BIT];
	wire logic  fall_clr = ctrl_wr & ~ctrl_wdata[cmp_edge_pkg::CTRL_FALL_BIT];
	wire logic  rise_d   = rise_det | (rise_flag_q & ~rise_clr);   // RL9 RL10 RL21
	wire logic  fall_d   = fall_det | (fall_flag_q & ~fall_clr);   // RL9 RL10 RL21

	////////////////////////////////////////////////////////////////////////////
	// Software settings. Writing 1 to a flag bit leaves it as it is.
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			enable_q  <= cmp_edge_pkg::CTRL_RESET[cmp_edge_pkg::CTRL_ENABLE_BIT];
			hyst_q    <= cmp_edge_pkg::CTRL_RESET[3:0];
			mux_q     <= cmp_edge_pkg::MUX_RESET;
			rise_ie_q <= cmp_edge_pkg::MODE_RESET[cmp_edge_pkg::MODE_RISE_IE_BIT];
			fall_ie_q <= cmp_edge_pkg::MODE_RESET[cmp_edge_pkg::MODE_FALL_IE_BIT];
			resp_q    <= cmp_edge_pkg::MODE_RESET[1:0];
		end
		else
		begin
			if (ctrl_wr)
			begin
				enable_q <= ctrl_wdata[cmp_edge_pkg::CTRL_ENABLE_BIT];   // RL12
				hyst_q   <= ctrl_wdata[3:0];   // RL7 RL18
			end
			if (mux_wr)
				mux_q <= mux_wdata;   // RL4
			if (mode_wr)
			begin
				rise_ie_q <= mode_wdata[cmp_edge_pkg::MODE_RISE_IE_BIT];
				fall_ie_q <= mode_wdata[cmp_edge_pkg::MODE_FALL_IE_BIT];
				resp_q    <= mode_wdata[1:0];   // RL6 RL19
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Synchroniser, edge flags and registered outputs. Flags may pick up false
	// edges while the core settles after a settings change; software clears them.
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync1_q     <= 1'b0;
			sync2_q     <= 1'b0;
			en_dly1_q   <= 1'b0;
			en_dly2_q   <= 1'b0;
			prev_q      <= 1'b0;
			rise_flag_q <= 1'b0;
			fall_flag_q <= 1'b0;
			latched_q   <= 1'b0;
			rise_irq_q  <= 1'b0;
			fall_irq_q  <= 1'b0;
			wake_q      <= 1'b0;
		end
		else
		begin
			sync1_q     <= cmp_decision;
			sync2_q     <= sync1_q;   // RL20
			en_dly1_q   <= enable_q;
			en_dly2_q   <= en_dly1_q;
			prev_q      <= out_state;
			rise_flag_q <= rise_d;   // RL14
			fall_flag_q <= fall_d;
			latched_q   <= out_state & enable_d;   // RL1 RL5
			rise_irq_q  <= rise_d & rise_ie_q & system_cmp_irq_enable;   // RL8 RL17
			fall_irq_q  <= fall_d & fall_ie_q & system_cmp_irq_enable;   // RL8 RL17
			wake_q      <= enable_q & ~out_state;   // RL13
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// The raw and reset-source paths are pure gating so they work with the clock
	// stopped; they are the outputs not taken from a flip-flop, by necessity.
	assign cmp_raw_out     = cmp_decision & enable_q;   // RL2 RL5
	assign cmp_reset_src   = cmp_decision & enable_q;   // RL3
	assign cmp_latched_out = latched_q;
	assign wake_request    = wake_q;
	assign rise_irq        = rise_irq_q;
	assign fall_irq        = fall_irq_q;
	assign cmp_power_on    = enable_q;
	assign pos_input_sel   = mux_q[3:0];
	assign neg_input_sel   = mux_q[7:4];
	assign pos_hyst_sel    = hyst_q[3:2];
	assign neg_hyst_sel    = hyst_q[1:0];
	assign response_time_sel = resp_q;
	assign cmp_control_reg = {enable_q, latched_q, rise_flag_q, fall_flag_q, hyst_q};   // RL11 RL16
	assign cmp_input_select_reg = mux_q;
	assign cmp_mode_reg    = {2'h0, rise_ie_q, fall_ie_q, 2'h0, resp_q};

	////////////////////////////////////////////////////////////////////////////
	a_rise_sets_flag: assert property (@(posedge clock) disable iff (!arst_n) // RL9
		rise_det |=> rise_flag_q)
		else $error("rise edge lost");
	a_fall_sets_flag: assert property (@(posedge clock) disable iff (!arst_n) // RL9
		fall_det |=> fall_flag_q)
		else $error("fall edge lost");
	a_flag_sticky: assert property (@(posedge clock) disable iff (!arst_n) // RL10
		rise_flag_q && !rise_clr |=> rise_flag_q)
		else $error("rise flag dropped");
	a_fall_sticky: assert property (@(posedge clock) disable iff (!arst_n) // RL10
		fall_flag_q && !fall_clr |=> fall_flag_q)
		else $error("fall flag dropped");
	a_clear_works: assert property (@(posedge clock) disable iff (!arst_n) // RL21
		fall_clr && !fall_det |=> !fall_flag_q)
		else $error("fall flag not cleared");
	a_rise_clears: assert property (@(posedge clock) disable iff (!arst_n) // RL21
		rise_clr && !rise_det |=> !rise_flag_q)
		else $error("rise flag not cleared");

	a_enable_write: assert property (@(posedge clock) disable iff (!arst_n) // RL12
		ctrl_wr |=> cmp_power_on == $past(ctrl_wdata[cmp_edge_pkg::CTRL_ENABLE_BIT]))
		else $error("enable wrong");
	a_hyst_write: assert property (@(posedge clock) disable iff (!arst_n) // RL7 RL18
		ctrl_wr |=> {pos_hyst_sel, neg_hyst_sel} == $past(ctrl_wdata[3:0]))
		else $error("hysteresis wrong");
	a_mux_write: assert property (@(posedge clock) disable iff (!arst_n) // RL4
		mux_wr |=> cmp_input_select_reg == $past(mux_wdata))
		else $error("input select wrong");
	a_mode_write: assert property (@(posedge clock) disable iff (!arst_n) // RL6 RL19
		mode_wr |=> response_time_sel == $past(mode_wdata[1:0]))
		else $error("response time wrong");

	a_disabled_low: assert property (@(posedge clock) disable iff (!arst_n) // RL5
		!enable_q |-> !cmp_latched_out)
		else $error("latched out not low");
	a_raw_gated: assert property (@(posedge clock) disable iff (!arst_n) // RL5 RL3
		!enable_q |-> !cmp_raw_out && !cmp_reset_src)
		else $error("raw out not low");
	a_wake_follow: assert property (@(posedge clock) disable iff (!arst_n) // RL13
		enable_q && !out_state |=> wake_request)
		else $error("wake missing");
	a_wake_off: assert property (@(posedge clock) disable iff (!arst_n) // RL13
		!enable_q |=> !wake_request)
		else $error("wake while disabled");

	a_irq_gate: assert property (@(posedge clock) disable iff (!arst_n) // RL17
		rise_irq |-> $past(rise_ie_q) && $past(system_cmp_irq_enable))
		else $error("irq ungated");
	a_fall_irq_gate: assert property (@(posedge clock) disable iff (!arst_n) // RL17
		fall_irq |-> $past(fall_ie_q) && $past(system_cmp_irq_enable))
		else $error("fall irq ungated");
	a_rise_irq_set: assert property (@(posedge clock) disable iff (!arst_n) // RL8
		rise_d && rise_ie_q && system_cmp_irq_enable |=> rise_irq)
		else $error("rise irq missing");
	a_sync_latch: assert property (@(posedge clock) disable iff (!arst_n) // RL20
		cmp_latched_out == ($past(out_state) && enable_q))
		else $error("latch mismatch");
endmodule : comparator_edge_control
`default_nettype wire

// file: verif/analog_core_model.sv
// Behavioural model of the analog comparator core that feeds the block.
`timescale 1ns/1ns
`default_nettype none
module analog_core_model (
	// Core control and commanded input difference.
	input  wire logic power_on,
	input  wire logic level,
	// Decision towards the block.
	output logic      decision
);
	// An unpowered core gives no trustworthy decision, so it shows the wrong one.
	assign decision = power_on ? level : ~level;
endmodule : analog_core_model
`default_nettype wire

// file: verif/comparator_edge_control_tb.sv
// Self-checking testbench for the comparator edge control block.
`timescale 1ns/1ns
`default_nettype none
module comparator_edge_control_tb;
	logic       clock, arst_n, level, dec, pwr, sys_ie, lat, raw, rsrc, wake, r_irq, f_irq;
	logic [2:0] wr_sel;
	logic [7:0] wdata, ctrl_q, mux_q, mode_q;
	logic [3:0] psel, nsel;
	logic [1:0] phys, nhys, resp;
	int         failures, n_checks;

	analog_core_model analog_core_model_i (.power_on(pwr), .level(level), .decision(dec));
	comparator_edge_control comparator_edge_control_i (
		.clock(clock), .arst_n(arst_n), .cmp_decision(dec), .cmp_power_on(pwr),
		.pos_input_sel(psel), .neg_input_sel(nsel), .pos_hyst_sel(phys), .neg_hyst_sel(nhys),
		.response_time_sel(resp), .ctrl_wr(wr_sel[0]), .ctrl_wdata(wdata),
		.mux_wr(wr_sel[1]), .mux_wdata(wdata), .mode_wr(wr_sel[2]), .mode_wdata(wdata),
		.system_cmp_irq_enable(sys_ie), .cmp_control_reg(ctrl_q),
		.cmp_input_select_reg(mux_q), .cmp_mode_reg(mode_q), .cmp_latched_out(lat),
		.cmp_raw_out(raw), .cmp_reset_src(rsrc), .wake_request(wake),
		.rise_irq(r_irq), .fall_irq(f_irq));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Index 0 control, 1 input select, 2 mode; strobe lasts one clock.
	task automatic wr(input int which, input logic [7:0] d);
		@(negedge clock);
		wdata = d;
		wr_sel = 3'h1 << which;
		@(negedge clock);
		wr_sel = 3'h0;
	endtask : wr

	task automatic test_done;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	initial
	begin
		arst_n = 1'b0;
		level = 1'b0;
		sys_ie = 1'b1;
		wr_sel = 3'h0;
		wdata = 8'h00;
		failures = 0;
		n_checks = 0;
		repeat (8) @(negedge clock);
		arst_n = 1'b1;
		chk(ctrl_q, 8'h00);
		chk(mux_q, 8'h77);
		chk({mode_q, resp}, {8'h02, 2'h2});
		$display("test reset values done");
		// Bit 6 is written high to show that the state bit ignores writes.
		wr(0, 8'hce);
		chk(ctrl_q, 8'h8e);
		chk({pwr, phys, nhys}, 5'h1e);
		wr(1, 8'h52);
		chk({nsel, psel}, 8'h52);
		wr(2, 8'hff);
		chk({mode_q, resp}, {8'h33, 2'h3});
		repeat (3) @(negedge clock);
		chk(wake, 1'b1);
		wr(0, 8'h8e);
		$display("test settings done");
		level = 1'b1;
		#1 chk({raw, rsrc, lat}, 3'h6);
		repeat (3) @(negedge clock);
		chk(ctrl_q, 8'hee);
		chk({lat, r_irq, f_irq, wake}, 4'hc);
		level = 1'b0;
		repeat (4) @(negedge clock);
		chk(ctrl_q, 8'hbe);
		chk({lat, r_irq, f_irq, wake}, 4'h7);
		sys_ie = 1'b0;
		@(negedge clock);
		chk({r_irq, f_irq}, 2'h0);
		wr(0, 8'hbe);
		chk(ctrl_q, 8'hbe);
		wr(0, 8'h8e);
		chk(ctrl_q, 8'h8e);
		// A clear that lands on the detecting edge must lose to the new edge.
		level = 1'b1;
		@(negedge clock);
		wr(0, 8'h8e);
		chk(ctrl_q, 8'hee);
		$display("test edges done");
		wr(0, 8'h00);
		repeat (3) @(negedge clock);
		chk({pwr, raw, rsrc, lat, wake}, 5'h00);
		$display("test disable done");
		test_done();
	end
endmodule : comparator_edge_control_tb
`default_nettype wire
